/* File: core/rms_pkg.sv */
// Purpose: constants shared by the radio mode select block
// Assumes: 5-bit register addresses, 8-bit register data
// Notes: register reset values are not documented; zero chosen
package rms_pkg;
  localparam logic [4:0] RMS_ADDR_BANK_SEL = 5'h00;
  localparam logic [4:0] RMS_ADDR_SRC_SEL = 5'h02;
  localparam logic [4:0] RMS_ADDR_BANK1 = 5'h06;
  localparam logic [4:0] RMS_ADDR_BANK2 = 5'h09;
  localparam int RMS_BANK_SEL_BIT = 0;
  localparam int RMS_SRC_SEL_BIT = 3;
  localparam int RMS_STATE_HI = 7;
  localparam int RMS_STATE_LO = 6;
  localparam logic [7:0] RMS_REG_RESET = 8'h00;
  localparam int RMS_ADDR_W = 5;
  localparam int RMS_DATA_W = 8;
  localparam int RMS_NREG = 4;
  localparam logic [1:0] RMS_ST_SLEEP = 2'h0;
  localparam logic [1:0] RMS_ST_STANDBY = 2'h1;
  localparam logic [1:0] RMS_ST_RX = 2'h2;
  localparam logic [1:0] RMS_ST_TX = 2'h3;
  localparam logic [4:0] RMS_FRAME_BITS = 5'h10;
  localparam logic [4:0] RMS_RW_BIT = 5'h00;
  localparam logic [4:0] RMS_ADDR_LAST_BIT = 5'h05;
  localparam logic [4:0] RMS_CMD_LAST_BIT = 5'h07;
  typedef enum logic [2:0] {
    RMS_SER_CMD = 3'b001,
    RMS_SER_DATA = 3'b010,
    RMS_SER_DONE = 3'b100
  } rms_ser_st_t;
endpackage

/* File: core/rms_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: single clock domain i_clk
// Notes: first flop read only by the second
`timescale 1ns/1ps
`default_nettype none
module rms_sync #(
  parameter int W = 1
) (
  // clock and control
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: core/rms_top.sv */
// Purpose: radio operating-state selection with 3-wire register port
// Assumes: serial clock sampled, much slower than i_clk
// Notes: frame = R/W bit, 5 address bits (A4 first), 2 pad bits, 8 data
//
// Functional notes
// - source bit picks register or pin bank
// - register bit 0 picks bank when source 0
// - pin drives high in transmit when source 0
// - source 1: pin input picks bank
// - bank one state from address 06
// - bank two state from address 09
// - 00 sleep 01 standby 10 rx 11 tx
// - registers reached over 3-wire serial bus
`timescale 1ns/1ps
`default_nettype none
module rms_top
  import rms_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // 3-wire serial register bus
  input wire logic i_serial_clock,
  input wire logic i_serial_en,
  input wire logic i_serial_in,
  output logic o_serial_out,
  // bank switch pin
  input wire logic i_bank_switch,
  output logic o_bank_switch,
  output logic o_bank_switch_oe,
  // antenna switch lines from the controller
  input wire logic i_antenna_rx_ctl,
  input wire logic i_antenna_tx_ctl,
  output logic o_antenna_rx,
  output logic o_antenna_tx,
  // operating state
  output logic [1:0] o_op_state,
  output logic o_sleep,
  output logic o_standby,
  output logic o_receive,
  output logic o_transmit,
  output logic o_bank_two
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pins_s;
  rms_sync #(.W(6)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async({i_serial_clock, i_serial_en, i_serial_in, i_bank_switch,
              i_antenna_rx_ctl, i_antenna_tx_ctl}),
    .o_sync(pins_s)
  );
  wire sck_s = pins_s[5];
  wire sen_s = pins_s[4];
  wire sdi_s = pins_s[3];
  wire sw_s = pins_s[2];
  wire arx_s = pins_s[1];
  wire atx_s = pins_s[0];

  // ----------------------------------------
  // serial register port
  // ----------------------------------------
  logic sck_d;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  rms_ser_st_t ser_st;
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic rd_flag;
  logic [4:0] addr;
  logic [7:0] regs [RMS_NREG];
  // map address to storage index; unmapped writes dropped, reads zero
  wire hit_bank = (addr == RMS_ADDR_BANK_SEL);
  wire hit_src = (addr == RMS_ADDR_SRC_SEL);
  wire hit_b1 = (addr == RMS_ADDR_BANK1);
  wire hit_b2 = (addr == RMS_ADDR_BANK2);
  wire hit_any = hit_bank | hit_src | hit_b1 | hit_b2;
  wire [1:0] idx = hit_src ? 2'h1 : hit_b1 ? 2'h2 : hit_b2 ? 2'h3 : 2'h0;
  wire [7:0] rd_data = hit_any ? regs[idx] : 8'h00;
  wire bit_take = sen_s && sck_rise;
  wire in_cmd = (ser_st == RMS_SER_CMD);
  wire in_data = (ser_st == RMS_SER_DATA);
  wire in_done = (ser_st == RMS_SER_DONE);
  wire rw_take = in_cmd && bit_take && (bit_cnt == RMS_RW_BIT);
  wire addr_done = in_cmd && bit_take && (bit_cnt == RMS_ADDR_LAST_BIT);
  wire cmd_done = in_cmd && bit_take && (bit_cnt == RMS_CMD_LAST_BIT);
  wire data_done = in_data && bit_take && (bit_cnt == RMS_FRAME_BITS - 5'h01);
  wire out_step = sen_s && in_data && sck_fall;
  // a dropped enable clears the data line too, so a cut frame leaves it low
  wire out_clear = !sen_s || in_done;
  wire [4:0] next_bit_cnt = !sen_s ? 5'h00 : (bit_take ? bit_cnt + 5'h01 : bit_cnt);
  wire [7:0] next_shift_in = {shift_in[6:0], sdi_s};
  rms_ser_st_t next_ser_st;

  always_comb begin
    next_ser_st = ser_st;
    unique case (ser_st)
      RMS_SER_CMD: begin
        if (cmd_done) begin
          next_ser_st = RMS_SER_DATA;
        end
      end
      RMS_SER_DATA: begin
        if (data_done) begin
          next_ser_st = RMS_SER_DONE;
        end
      end
      RMS_SER_DONE: begin
        next_ser_st = RMS_SER_DONE;
      end
    endcase
    // enable low aborts any frame in flight
    if (!sen_s) begin
      next_ser_st = RMS_SER_CMD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sck_d <= 1'b0;
      ser_st <= RMS_SER_CMD;
      bit_cnt <= 5'h00;
    end else if (i_ce) begin
      sck_d <= sck_s;
      ser_st <= next_ser_st;
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      shift_in <= 8'h00;
      rd_flag <= 1'b0;
      addr <= 5'h00;
    end else if (i_ce) begin
      if (bit_take) begin
        shift_in <= next_shift_in;
      end
      if (rw_take) begin
        rd_flag <= sdi_s;
      end
      if (addr_done) begin
        addr <= next_shift_in[4:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      shift_out <= 8'h00;
      o_serial_out <= 1'b0;
    end else if (i_ce) begin
      if (cmd_done) begin
        shift_out <= rd_data;
      end else if (out_step) begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
      if (out_clear) begin
        o_serial_out <= 1'b0;
      end else if (out_step) begin
        o_serial_out <= shift_out[7];
      end
    end
  end

  // register write at the last data bit
  wire wr_en = data_done && !rd_flag && hit_any;
  genvar g;
  generate
    for (g = 0; g < RMS_NREG; g++) begin : g_reg
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          regs[g] <= RMS_REG_RESET;
        end else if (i_ce && wr_en && idx == g) begin
          regs[g] <= {shift_in[6:0], sdi_s};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // bank and state selection
  // ----------------------------------------
  wire src_pin = regs[1][RMS_SRC_SEL_BIT];
  wire bank_reg = regs[0][RMS_BANK_SEL_BIT];
  // pin read only while we do not drive it
  wire bank_sel = src_pin ? sw_s : bank_reg;
  wire [1:0] st_b1 = regs[2][RMS_STATE_HI:RMS_STATE_LO];
  wire [1:0] st_b2 = regs[3][RMS_STATE_HI:RMS_STATE_LO];
  wire [1:0] next_state = bank_sel ? st_b2 : st_b1;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_op_state <= RMS_ST_SLEEP;
      o_sleep <= 1'b1;
      o_standby <= 1'b0;
      o_receive <= 1'b0;
      o_transmit <= 1'b0;
      o_bank_two <= 1'b0;
      o_bank_switch <= 1'b0;
      o_bank_switch_oe <= 1'b0;
      o_antenna_rx <= 1'b0;
      o_antenna_tx <= 1'b0;
    end else if (i_ce) begin
      o_op_state <= next_state;
      o_sleep <= (next_state == RMS_ST_SLEEP);
      o_standby <= (next_state == RMS_ST_STANDBY);
      o_receive <= (next_state == RMS_ST_RX);
      o_transmit <= (next_state == RMS_ST_TX);
      o_bank_two <= bank_sel;
      o_bank_switch_oe <= ~src_pin;
      o_bank_switch <= ~src_pin && (next_state == RMS_ST_TX);
      // antenna follows controller lines; both high is refused
      o_antenna_rx <= arx_s & ~atx_s;
      o_antenna_tx <= atx_s & ~arx_s;
    end
  end
endmodule
`default_nettype wire

/* File: sim/rms_top_monitor.sv */
// Purpose: port-level checks for rms_top
// Assumes: checks paused while i_ce is low
// Notes: pin and antenna inputs pass synchronisers, so a few cycles of margin
`timescale 1ns/1ps
`default_nettype none
module rms_top_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_serial_en,
  input wire logic i_bank_switch,
  input wire logic i_antenna_rx_ctl,
  input wire logic i_antenna_tx_ctl,
  input wire logic o_serial_out,
  input wire logic o_bank_switch,
  input wire logic o_bank_switch_oe,
  input wire logic o_antenna_rx,
  input wire logic o_antenna_tx,
  input wire logic [1:0] o_op_state,
  input wire logic o_sleep,
  input wire logic o_standby,
  input wire logic o_receive,
  input wire logic o_transmit,
  input wire logic o_bank_two
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst || !i_ce);
  chk_tx_decode: assert property (o_transmit == (o_op_state == 2'h3))
    else $error("transmit flag disagrees with state");
  chk_sleep_decode: assert property (o_sleep == (o_op_state == 2'h0))
    else $error("sleep flag disagrees with state");
  chk_stby_decode: assert property (o_standby == (o_op_state == 2'h1))
    else $error("standby flag disagrees with state");
  chk_rx_decode: assert property (o_receive == (o_op_state == 2'h2))
    else $error("receive flag disagrees with state");
  chk_pin_tx: assert property (o_bank_switch_oe |-> o_bank_switch == o_transmit)
    else $error("driven pin does not follow transmit");
  chk_pin_high: assert property ((!o_bank_switch_oe && i_bank_switch) [*4] |-> o_bank_two)
    else $error("pin high did not pick bank two");
  chk_pin_low: assert property ((!o_bank_switch_oe && !i_bank_switch) [*4] |-> !o_bank_two)
    else $error("pin low did not pick bank one");
  chk_ant_rx: assert property ((i_antenna_rx_ctl && !i_antenna_tx_ctl) [*4] |-> o_antenna_rx && !o_antenna_tx)
    else $error("antenna lines not copied");
  chk_ant_excl: assert property (!(o_antenna_rx && o_antenna_tx))
    else $error("both antenna lines high");
  chk_sout_idle: assert property ((!i_serial_en) [*6] |-> !o_serial_out)
    else $error("serial out busy outside frame");
endmodule
bind rms_top rms_top_monitor u_mon (.*);
`default_nettype wire

/* File: sim/rms_mcu_model.sv */
// Purpose: controller side of the 3-wire register bus
// Assumes: serial clock high 6 and low 12 system clocks
// Notes: clock stands low between frames; data line inverted once released
`timescale 1ns/1ps
`default_nettype none
module rms_mcu_model (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_sen,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_sen = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, 2'b00, d};
    q = 8'h00;
    @(posedge i_clk) o_sen <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      o_sdi <= f[i];
      repeat (12) @(posedge i_clk);
      if (i < 8) q[i] = i_sdo;
      o_sclk <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    o_sen <= 1'b0;
    o_sdi <= ~o_sdi;
    repeat (6) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for rms_top
// Assumes: controller model owns the serial lines
// Notes: pin level resolved from the device enable
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rms_pkg::*;
;
  logic clk = 0, rst = 1, ce = 1, pin = 0, arx = 0, atx = 0;
  wire sclk, sen, sdi, sout, bsw, oe, orx, otx, two, slp, stb, rcv, txf;
  wire [1:0] st;
  int n_fail = 0, n_checks = 0;
  always #25 clk = ~clk;
  rms_mcu_model mcu (.i_clk(clk), .i_sdo(sout), .o_sclk(sclk), .o_sen(sen), .o_sdi(sdi));
  rms_top dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_serial_clock(sclk), .i_serial_en(sen),
    .i_serial_in(sdi), .o_serial_out(sout), .i_bank_switch(oe ? bsw : pin), .o_bank_switch(bsw),
    .o_bank_switch_oe(oe), .i_antenna_rx_ctl(arx), .i_antenna_tx_ctl(atx), .o_antenna_rx(orx),
    .o_antenna_tx(otx), .o_op_state(st), .o_sleep(slp), .o_standby(stb), .o_receive(rcv), .o_transmit(txf),
    .o_bank_two(two));
  task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    mcu.xfer(1'b0, a, d, q);
    repeat (8) @(posedge clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    mcu.xfer(1'b1, a, 8'h00, q);
    check("readback", q, e);
  endtask
  task automatic t_regs;
    rdchk(RMS_ADDR_BANK1, RMS_REG_RESET);
    wr(RMS_ADDR_BANK2, 8'h5a);
    rdchk(RMS_ADDR_BANK2, 8'h5a);
    wr(5'h1f, 8'hff);
    rdchk(5'h1f, 8'h00);
  endtask
  task automatic t_reg_bank;
    for (int s = 0; s < 4; s++) begin
      wr(RMS_ADDR_BANK1, {s[1:0], 6'h00});
      wr(RMS_ADDR_BANK2, {~s[1:0], 6'h3f});
      wr(RMS_ADDR_BANK_SEL, 8'h00);
      check("state", {6'h00, st}, {6'h00, s[1:0]});
      check("flags", {4'h0, txf, rcv, stb, slp}, 8'h01 << s[1:0]);
      check("bank", {7'h00, two}, 8'h00);
      check("pin", {7'h00, bsw}, {7'h00, s == 3});
      check("oe", {7'h00, oe}, 8'h01);
      wr(RMS_ADDR_BANK_SEL, 8'h01);
      check("state", {6'h00, st}, {6'h00, ~s[1:0]});
      check("flags", {4'h0, txf, rcv, stb, slp}, 8'h01 << ~s[1:0]);
      check("bank", {7'h00, two}, 8'h01);
      check("pin", {7'h00, bsw}, {7'h00, s == 0});
    end
  endtask
  task automatic t_pin_bank;
    wr(RMS_ADDR_BANK1, 8'h80);
    wr(RMS_ADDR_BANK2, 8'hc0);
    wr(RMS_ADDR_SRC_SEL, 8'h08);
    check("oe", {7'h00, oe}, 8'h00);
    check("state", {6'h00, st}, 8'h02);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    check("state", {6'h00, st}, 8'h03);
  endtask
  task automatic t_ce;
    ce <= 1'b0;
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    check("frozen", {6'h00, st}, {6'h00, RMS_ST_TX});
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    check("state", {6'h00, st}, {6'h00, RMS_ST_RX});
  endtask
  task automatic t_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset state", {6'h00, st}, {6'h00, RMS_ST_SLEEP});
    check("reset flags", {4'h0, txf, rcv, stb, slp}, 8'h01);
    check("reset oe", {7'h00, oe}, 8'h01);
    rdchk(RMS_ADDR_SRC_SEL, RMS_REG_RESET);
  endtask
  task automatic t_antenna;
    arx <= 1'b1;
    repeat (6) @(posedge clk);
    check("antenna", {6'h00, orx, otx}, 8'h02);
    arx <= 1'b0;
    atx <= 1'b1;
    repeat (6) @(posedge clk);
    check("antenna", {6'h00, orx, otx}, 8'h01);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_reg_bank;
    t_pin_bank;
    t_ce;
    t_antenna;
    t_reset;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule
`default_nettype wire
